// File: core/bbs_sequencer.sv
// Backup battery switchover sequencer
module bbs_sequencer (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // Comparator flags, already synchronised
    input  wire logic        supply_below_off_in,
    input  wire logic        supply_above_recover_in,
    input  wire logic        supply_absent_in,
    // Alarm delay configuration and slow tick
    input  wire logic [15:0] alarm_delay_in,
    input  wire logic        delay_tick_in,
    // System controller handshake
    input  wire logic        report_done_in,
    // Supply selection and measurement
    output logic             battery_select_out,
    output logic             supply_meas_zero_out,
    // Message request and log events
    output logic             malfunction_req_out,
    output logic             log_battery_switch_out,
    output logic             log_battery_value_out,
    output logic             log_supply_restored_out,
    // Load enables, battery indicator and monitor-only flag
    output logic             analog_out_en_out,
    output logic             relay_led_en_out,
    output logic             serial_aux_en_out,
    output logic             relay_drive_en_out,
    output logic             battery_led_out,
    output logic             monitor_only_out
);
    bbs_pkg::bbs_state_t state_reg;
    bbs_pkg::bbs_state_t state_next;
    logic [15:0]         delay_cnt_reg;
    logic                delay_done;

    // Zero delay counts as already expired
    assign delay_done = (delay_cnt_reg == bbs_pkg::DELAY_ZERO);

    // Switchover decode, shared by the counter, the log and the checks
    function automatic logic switch_start(input bbs_pkg::bbs_state_t st,
                                          input logic                below);
        return (st == bbs_pkg::BBS_MAIN) && below;
    endfunction

    // Return to main from either waiting state
    function automatic logic restore_start(input bbs_pkg::bbs_state_t st,
                                           input logic                above);
        return ((st == bbs_pkg::BBS_MONITOR) || (st == bbs_pkg::BBS_OFF)) && above;
    endfunction

    // Loads and the live measurement follow the main state only
    function automatic logic on_main(input bbs_pkg::bbs_state_t st);
        return st == bbs_pkg::BBS_MAIN;
    endfunction

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bbs_pkg::BBS_MAIN: begin
                if (supply_below_off_in) begin
                    state_next = bbs_pkg::BBS_DELAY;
                end
            end
            bbs_pkg::BBS_DELAY: begin
                if (supply_above_recover_in) begin
                    state_next = bbs_pkg::BBS_MAIN;
                end else if (delay_done) begin
                    state_next = bbs_pkg::BBS_REPORT;
                end
            end
            bbs_pkg::BBS_REPORT: begin
                if (report_done_in) begin
                    state_next = supply_absent_in ? bbs_pkg::BBS_OFF : bbs_pkg::BBS_MONITOR;
                end
            end
            bbs_pkg::BBS_MONITOR: begin
                if (supply_above_recover_in) begin
                    state_next = bbs_pkg::BBS_MAIN;
                end else if (supply_absent_in) begin
                    state_next = bbs_pkg::BBS_OFF;
                end
            end
            bbs_pkg::BBS_OFF: begin
                // Power returning after full loss restarts normally
                if (supply_above_recover_in) begin
                    state_next = bbs_pkg::BBS_MAIN;
                end
            end
            default: state_next = bbs_pkg::BBS_MAIN;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_reg <= bbs_pkg::BBS_MAIN;
        end else begin
            state_reg <= state_next;
        end
    end

    // delay loaded on switchover, counts slow ticks
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            delay_cnt_reg <= bbs_pkg::DELAY_ZERO;
        end else if (switch_start(state_reg, supply_below_off_in)) begin
            delay_cnt_reg <= alarm_delay_in;
        end else if (state_reg == bbs_pkg::BBS_DELAY && delay_tick_in && !delay_done) begin
            delay_cnt_reg <= delay_cnt_reg - bbs_pkg::DELAY_STEP;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            log_battery_switch_out  <= 1'h0;
            log_battery_value_out   <= bbs_pkg::LOG_VAL_MAIN;
            log_supply_restored_out <= 1'h0;
        end else begin
            // pulses drop on their own; the value holds for slow readers
            log_battery_switch_out  <= 1'h0;
            log_supply_restored_out <= 1'h0;
            if (switch_start(state_reg, supply_below_off_in)) begin
                log_battery_switch_out <= 1'h1;
                log_battery_value_out  <= bbs_pkg::LOG_VAL_BATTERY;
            end else if (state_reg == bbs_pkg::BBS_DELAY && supply_above_recover_in) begin
                log_battery_switch_out <= 1'h1;
                log_battery_value_out  <= bbs_pkg::LOG_VAL_MAIN;
            end else if (restore_start(state_reg, supply_above_recover_in)) begin
                log_supply_restored_out <= 1'h1;
            end
        end
    end

    // Outputs decoded from next state so they align with state_reg
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            battery_select_out   <= 1'h0;
            supply_meas_zero_out <= 1'h0;
            malfunction_req_out  <= 1'h0;
            battery_led_out      <= 1'h0;
            monitor_only_out     <= 1'h0;
            analog_out_en_out    <= 1'h1;
            relay_led_en_out     <= 1'h1;
            serial_aux_en_out    <= 1'h1;
            relay_drive_en_out   <= 1'h1;
        end else begin
            battery_select_out   <= (state_next == bbs_pkg::BBS_DELAY)
                                    || (state_next == bbs_pkg::BBS_REPORT);
            supply_meas_zero_out <= !on_main(state_next);
            // request only after expiry, never from DELAY
            malfunction_req_out  <= (state_next == bbs_pkg::BBS_REPORT);
            battery_led_out      <= (state_next == bbs_pkg::BBS_REPORT);
            // battery already released; only the comparators stay live
            monitor_only_out     <= (state_next == bbs_pkg::BBS_MONITOR);
            // loads run only on main supply
            // Relays drop at once so the contacts rest normally open
            analog_out_en_out    <= on_main(state_next);
            relay_led_en_out     <= on_main(state_next);
            serial_aux_en_out    <= on_main(state_next);
            relay_drive_en_out   <= on_main(state_next);
        end
    end

    property p_switch_log;
        @(posedge mclk_in) disable iff (!rstn_in)
        switch_start(state_reg, supply_below_off_in)
            |=> log_battery_switch_out && log_battery_value_out && battery_select_out;
    endproperty
    a_switch_log: assert property (p_switch_log) else $error("No battery log on switchover");

    property p_meas_zero;
        @(posedge mclk_in) disable iff (!rstn_in)
        battery_select_out |-> supply_meas_zero_out;
    endproperty
    a_meas_zero: assert property (p_meas_zero) else $error("Measurement not zero");

    property p_zero_delay;
        @(posedge mclk_in) disable iff (!rstn_in)
        (switch_start(state_reg, supply_below_off_in) && alarm_delay_in == bbs_pkg::DELAY_ZERO)
            ##1 !supply_above_recover_in |=> malfunction_req_out;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("Zero delay not immediate");

    property p_recover_log;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_DELAY && supply_above_recover_in)
            |=> log_battery_switch_out && !log_battery_value_out && !battery_select_out;
    endproperty
    a_recover_log: assert property (p_recover_log) else $error("Bad recovery log");

    property p_no_req_recover;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_DELAY && supply_above_recover_in) |=> !malfunction_req_out;
    endproperty
    a_no_req_recover: assert property (p_no_req_recover) else $error("Request not cancelled");

    property p_expiry;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_DELAY && delay_done && !supply_above_recover_in)
            |=> malfunction_req_out && battery_led_out;
    endproperty
    a_expiry: assert property (p_expiry) else $error("No request at expiry");

    property p_loads_off;
        @(posedge mclk_in) disable iff (!rstn_in)
        battery_select_out |-> !analog_out_en_out && !relay_led_en_out
            && !serial_aux_en_out && !relay_drive_en_out;
    endproperty
    a_loads_off: assert property (p_loads_off) else $error("Load on while on battery");

    property p_release;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_REPORT && report_done_in)
            |=> !battery_select_out && !battery_led_out;
    endproperty
    a_release: assert property (p_release) else $error("Battery not released");

    property p_restore;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_MONITOR && supply_above_recover_in)
            |=> log_supply_restored_out && analog_out_en_out;
    endproperty
    a_restore: assert property (p_restore) else $error("No restore");

    property p_pulse;
        @(posedge mclk_in) disable iff (!rstn_in)
        log_battery_switch_out |=> !log_battery_switch_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("Log longer than a cycle");

    property p_restored_pulse;
        @(posedge mclk_in) disable iff (!rstn_in)
        log_supply_restored_out |=> !log_supply_restored_out;
    endproperty
    a_restored_pulse: assert property (p_restored_pulse) else $error("Long restore log");

    // One tick takes exactly one off the count, never wrapping below zero
    property p_count_step;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_DELAY && delay_tick_in && !delay_done)
            |=> delay_cnt_reg == $past(delay_cnt_reg) - bbs_pkg::DELAY_STEP;
    endproperty
    a_count_step: assert property (p_count_step) else $error("Delay count step wrong");

    property p_delay_quiet;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_DELAY) |-> battery_select_out && !malfunction_req_out;
    endproperty
    a_delay_quiet: assert property (p_delay_quiet) else $error("Request during delay");

    property p_main_loads;
        @(posedge mclk_in) disable iff (!rstn_in)
        !supply_meas_zero_out |-> analog_out_en_out && relay_led_en_out
            && serial_aux_en_out && relay_drive_en_out;
    endproperty
    a_main_loads: assert property (p_main_loads) else $error("Load off on main supply");

    property p_led_report;
        @(posedge mclk_in) disable iff (!rstn_in)
        battery_led_out |-> malfunction_req_out && battery_select_out;
    endproperty
    a_led_report: assert property (p_led_report) else $error("Indicator without report");

    property p_monitor_quiet;
        @(posedge mclk_in) disable iff (!rstn_in)
        monitor_only_out |-> !battery_select_out && !malfunction_req_out
            && !analog_out_en_out && !relay_drive_en_out;
    endproperty
    a_monitor_quiet: assert property (p_monitor_quiet) else $error("Monitor not quiet");

    property p_vanish;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_MONITOR && supply_absent_in && !supply_above_recover_in)
            |=> !monitor_only_out;
    endproperty
    a_vanish: assert property (p_vanish) else $error("Monitor kept after supply loss");

    property p_restore_off;
        @(posedge mclk_in) disable iff (!rstn_in)
        (state_reg == bbs_pkg::BBS_OFF && supply_above_recover_in)
            |=> log_supply_restored_out && relay_drive_en_out;
    endproperty
    a_restore_off: assert property (p_restore_off) else $error("No restore after loss");

    c_switch: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        log_battery_switch_out && log_battery_value_out);
    c_recover: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        log_battery_switch_out && !log_battery_value_out);
    c_monitor: cover property (@(posedge mclk_in) disable iff (!rstn_in) monitor_only_out);
    c_restore: cover property (@(posedge mclk_in) disable iff (!rstn_in) log_supply_restored_out);
    c_expire: cover property (@(posedge mclk_in) disable iff (!rstn_in) malfunction_req_out);
endmodule

// File: pkg/bbs_pkg.sv
// Constants and state type for the backup battery switchover sequencer
// Overview of operation
// - Below off threshold: select battery, force supply measurement value to zero.
// - Alarm delay zero requests malfunction message at once, else after delay.
// - Each switchover onto battery pulses battery-switch log event with value one.
// - During alarm delay on battery, everything runs except battery-disabled loads.
// - Recovery above threshold during delay returns to main, logs value zero.
// - Recovery during delay cancels pending malfunction request for that event.
// - Delay expiry while still below recover threshold asserts malfunction request.
// - On battery: analogue outputs, relay LEDs, serial 5V and relay drives off.
// - Battery indicator LED lit while connecting to send the malfunction message.
// - After message sent, disconnect battery and switch indicator LED off.
// - Supply partly present after disconnect: monitor only until gone or recovered.
// - From monitor-only, recovery resumes normal operation and logs supply restored.
package bbs_pkg;
    localparam int unsigned DELAY_W         = 16;
    localparam logic [15:0] DELAY_ZERO      = 16'h0000;
    localparam logic [15:0] DELAY_STEP      = 16'h0001;
    localparam logic        LOG_VAL_BATTERY = 1'h1;
    localparam logic        LOG_VAL_MAIN    = 1'h0;

    typedef enum logic [2:0] {
        BBS_MAIN,
        BBS_DELAY,
        BBS_REPORT,
        BBS_MONITOR,
        BBS_OFF
    } bbs_state_t;
endpackage

// File: bench/bbs_partner.sv
// Model of the supply comparators and the system controller
module bbs_partner (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // Supply level 0 gone, 1 low, 2 partial, 3 good; controller answer delay
    input  wire logic [1:0] level_in,
    input  wire logic [2:0] done_wait_in,
    input  wire logic       req_in,
    // Flags, tick and answer
    output logic            below_out,
    output logic            above_out,
    output logic            absent_out,
    output logic            tick_out,
    output logic            done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] tick_cnt;
    logic [2:0] wait_cnt;
    always_ff @(posedge mclk_in) begin
        below_out  <= rstn_in && (level_in < 2'h2);
        above_out  <= rstn_in && (level_in == 2'h3);
        absent_out <= rstn_in && (level_in == 2'h0);
        tick_cnt   <= rstn_in ? tick_cnt + 2'h1 : 2'h0;
        tick_out   <= rstn_in && (tick_cnt == 2'h3);
    end
    // Answers only while asked, after a chosen wait
    always_ff @(posedge mclk_in) begin
        wait_cnt <= (rstn_in && req_in) ? wait_cnt + 3'h1 : 3'h0;
        done_out <= rstn_in && req_in && (wait_cnt == done_wait_in);
    end
endmodule

// File: bench/tb.sv
// Self-checking bench for the backup battery switchover sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_in = 1'h0, rstn_in = 1'h0, seen;
    logic [1:0]  level = 2'h3;
    logic [2:0]  done_wait = 3'h0;
    logic [15:0] alarm_delay_in = 16'h0000;
    logic        supply_below_off_in, supply_above_recover_in, supply_absent_in;
    logic        delay_tick_in, report_done_in, battery_select_out, supply_meas_zero_out;
    logic        malfunction_req_out, log_battery_switch_out, log_battery_value_out;
    logic        log_supply_restored_out, analog_out_en_out, relay_led_en_out;
    logic        serial_aux_en_out, relay_drive_en_out, battery_led_out, monitor_only_out;
    int          mismatches = 0, cmp_count = 0, n, d;

    bbs_sequencer DUT (.mclk_in, .rstn_in, .supply_below_off_in, .supply_above_recover_in,
        .supply_absent_in, .alarm_delay_in, .delay_tick_in, .report_done_in,
        .battery_select_out, .supply_meas_zero_out, .malfunction_req_out,
        .log_battery_switch_out, .log_battery_value_out, .log_supply_restored_out,
        .analog_out_en_out, .relay_led_en_out, .serial_aux_en_out, .relay_drive_en_out,
        .battery_led_out, .monitor_only_out);
    bbs_partner far_side (.mclk_in(mclk_in), .rstn_in(rstn_in), .level_in(level),
        .done_wait_in(done_wait), .req_in(malfunction_req_out),
        .below_out(supply_below_off_in), .above_out(supply_above_recover_in),
        .absent_out(supply_absent_in), .tick_out(delay_tick_in), .done_out(report_done_in));

    initial forever #25 mclk_in = ~mclk_in;

    task automatic chk(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %0b seen %0b", what, exp, got);
        end
    endtask
    task automatic chk_loads(input logic exp);
        chk("analog_en", exp, analog_out_en_out);
        chk("relay_led_en", exp, relay_led_en_out);
        chk("serial_aux_en", exp, serial_aux_en_out);
        chk("relay_drive_en", exp, relay_drive_en_out);
    endtask
    function automatic logic sel(input int id);
        case (id)
            0: return log_battery_switch_out;
            1: return malfunction_req_out;
            2: return !battery_select_out;
            default: return log_supply_restored_out;
        endcase
    endfunction
    localparam int TICK_PER = 4;
    // First sight of the request, in falling edges after the switchover settled
    function automatic logic req_in_window(input int dly, input int cnt);
        if (dly == 0)
            return cnt == 0;
        return (cnt >= TICK_PER * dly - 3) && (cnt <= TICK_PER * dly);
    endfunction
    // Bounded wait, sampled at the falling edge where outputs are settled
    task automatic wait_hi(input int id, input int lim, output int cnt);
        cnt = 0;
        while (sel(id) !== 1'h1 && cnt < lim) begin
            @(negedge mclk_in);
            cnt++;
        end
        chk("wait_reached", 1'h1, sel(id));
    endtask
    task automatic drop(input logic [15:0] dly, input logic [1:0] lvl);
        @(posedge mclk_in);
        alarm_delay_in <= dly;
        level <= lvl;
        wait_hi(0, 6, n);
        chk("log_value", 1'h1, log_battery_value_out);
        chk("battery_sel", 1'h1, battery_select_out);
        chk("meas_zero", 1'h1, supply_meas_zero_out);
        chk("req_early", 1'h0, malfunction_req_out);
        chk_loads(1'h0);
        @(negedge mclk_in);
        chk("switch_pulse", 1'h0, log_battery_switch_out);
    endtask
    task automatic conclude;
        $display("Checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        n = $urandom(70);
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'h1;
        @(negedge mclk_in);
        chk("rst_battery", 1'h0, battery_select_out);
        chk("rst_log", 1'h0, log_battery_switch_out);
        chk_loads(1'h1);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 0 : $urandom_range(3, 1);
            done_wait <= 3'($urandom_range(7, 0));
            // Absent flag must settle before the controller can answer
            drop(16'(d), (i == 3) ? 2'h0 : 2'h1);
            wait_hi(1, 4 * d + 6, n);
            chk("req_time", 1'h1, req_in_window(d, n));
            chk("battery_led", 1'h1, battery_led_out);
            @(posedge mclk_in);
            level <= (i == 3) ? 2'h0 : 2'h2;
            wait_hi(2, 20, n);
            chk("battery_led_off", 1'h0, battery_led_out);
            chk("monitor", i != 3, monitor_only_out);
            chk_loads(1'h0);
            if (i == 1) begin
                @(posedge mclk_in);
                level <= 2'h0;
                repeat (3) @(negedge mclk_in);
                chk("monitor_vanish", 1'h0, monitor_only_out);
            end
            @(posedge mclk_in);
            level <= 2'h3;
            wait_hi(3, 6, n);
            chk_loads(1'h1);
            @(negedge mclk_in);
            chk("restored_pulse", 1'h0, log_supply_restored_out);
        end
        drop(16'h0064, 2'h1);
        @(posedge mclk_in);
        level <= 2'h3;
        wait_hi(0, 6, n);
        chk("log_value_main", 1'h0, log_battery_value_out);
        chk("battery_back", 1'h0, battery_select_out);
        chk_loads(1'h1);
        seen = 1'h0;
        repeat (450) begin
            @(negedge mclk_in);
            seen = seen | malfunction_req_out;
        end
        chk("req_cancelled", 1'h0, seen);
        // Reset in the middle of a running delay
        drop(16'h0064, 2'h1);
        @(posedge mclk_in);
        rstn_in <= 1'h0;
        level   <= 2'h3;
        repeat (2) @(negedge mclk_in);
        chk("mid_rst_battery", 1'h0, battery_select_out);
        chk("mid_rst_log", 1'h0, log_battery_switch_out);
        chk_loads(1'h1);
        @(posedge mclk_in);
        rstn_in <= 1'h1;
        repeat (4) @(negedge mclk_in);
        chk("post_rst_battery", 1'h0, battery_select_out);
        chk("post_rst_req", 1'h0, malfunction_req_out);
        conclude();
    end

    initial begin
        repeat (5000) @(posedge mclk_in);
        mismatches++;
        conclude();
    end
endmodule
